// *** verilog/nfh_host.sv ***
// Flash host controller: AXI4-Lite registers to NAND pin cycles
// Behaviour
// R01: Command bytes latched on write strobe rise, CLE
// R02: Address bytes latched on write strobe rise, ALE
// R03: Select high while ready gives standby
// R04: Select ignored by device while busy
// R05: Each read strobe fall yields next byte
// R06: Guard low inhibits program and erase
// R07: Ready/busy is open drain, low busy
// R08: Five address bytes, least significant first
// R09: Column, page and block bit split
// R10: Page holds 4224 bytes
// R11: 64 pages per block, 4096 blocks
// R12: Cycle kind decoded from strobe levels
// R13: Host keeps guard high during program/erase; guard follows the CTRL guard bit, so only software writing it high does this
// R14: Host keeps strobes high while busy; go ignores ready, so only software holding off writes does this
// R15: Only status and reset accepted while busy
// R16: Page read 00 then 30, copy 35
// R17: Column change 05 then E0
// R18: Data input 80, program 10, 85 change
// R19: Multi page 11 then 81 and 10
// R20: Erase 60 D0, ID 90, ECC 7A
// R21: Device drives port while read strobe low
// R22: Read code preloaded after power on
// R23: ID bytes follow 90 and one address
`timescale 1ns/1ps
`include "nfh_cfg.svh"
module nfh_host
  import nfh_pkg::*;
#(
  parameter int STROBE_CYC = `NFH_STROBE_CYC,
  parameter int WHR_CYC    = `NFH_WHR_CYC
)
(
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic [3:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [3:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic             o_cmd_latch,
  output logic             o_addr_latch,
  output logic             o_select_n,
  output logic             o_write_strobe_n,
  output logic             o_read_strobe_n,
  output logic             o_guard_n,
  input  wire logic [7:0]  i_shared_byte_port,
  output logic [7:0]       o_shared_byte_port,
  output logic             o_shared_byte_port_oe,
  input  wire logic        i_ready_busy_n
);
  // Counters are eight bits; longer strobes would wrap
  if (STROBE_CYC < 1 || STROBE_CYC + `NFH_REA_CYC > 255 ||
      WHR_CYC < 1 || WHR_CYC > 255)
  begin
    $error("nfh_host: strobe counts out of range");
  end

  typedef enum logic [2:0]
  {
    NFH_IDLE,
    NFH_SETUP,
    NFH_LOW,
    NFH_HIGH,
    NFH_WAIT
  } nfh_state_t;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: port bytes and ready/busy come from outside
  logic [8:0] pin_sync;
  logic [7:0] port_in;
  logic       ready_in;

  nfh_sync #(.W(9)) u_sync
  (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_async    ({i_ready_busy_n, i_shared_byte_port}),
    .o_sync     (pin_sync)
  );
  assign port_in  = pin_sync[7:0];
  assign ready_in = pin_sync[8]; // R07

  ////////////////////////////////////////////////////////////////////////
  // State
  nfh_state_t st_q, st_d;
  nfh_kind_t  kind_q, kind_d;
  logic [7:0] cnt_q, cnt_d, byte_q, byte_d, rbyte_q, rbyte_d;
  logic       guard_q, guard_d, sel_q, sel_d;
  logic       cle_q, cle_d, ale_q, ale_d, we_q, we_d, re_q, re_d;
  logic       oe_q, oe_d, done_q, done_d;
  logic       aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic       awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;
  logic [3:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic       go;

  // Register read mux, decoded by offset
  function automatic logic [31:0] rd_mux(input logic [3:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      `NFH_REG_CTRL:
      begin
        v[`NFH_F_KIND_HI:`NFH_F_KIND_LO] = kind_q;
        v[`NFH_F_GUARD]  = guard_q;
        v[`NFH_F_SELECT] = sel_q;
      end
      `NFH_REG_STAT:
      begin
        v[`NFH_ST_BUSY]  = (st_q != NFH_IDLE);
        v[`NFH_ST_READY] = ready_in;
      end
      `NFH_REG_RDATA: v[7:0] = rbyte_q;
      default:        v = '0;
    endcase
    return v;
  endfunction

  // A write to the data register starts one pin cycle; done blocks a
  // second start while the held write is being retired
  assign go = aw_q && w_q && !bv_q && !done_q && (st_q == NFH_IDLE)
              && (awa_q == `NFH_REG_DATA);

  ////////////////////////////////////////////////////////////////////////
  // Bus slave and pin sequencer next-state
  always_comb
  begin
    st_d = st_q; kind_d = kind_q; cnt_d = cnt_q; byte_d = byte_q;
    rbyte_d = rbyte_q; guard_d = guard_q; sel_d = sel_q;
    cle_d = cle_q; ale_d = ale_q; we_d = we_q; re_d = re_q;
    oe_d = oe_q; done_d = 1'b0;
    aw_d = aw_q; w_d = w_q; bv_d = bv_q; rv_d = rv_q;
    awa_d = awa_q; wd_d = wd_q; rd_d = rd_q;
    if (i_awvalid && !aw_q)
    begin
      aw_d = 1'b1;
      awa_d = i_awaddr;
    end
    if (i_wvalid && !w_q)
    begin
      w_d = 1'b1;
      wd_d = i_wdata;
    end
    if (bv_q && i_bready)
      bv_d = 1'b0;
    if (i_arvalid && !rv_q)
    begin
      rv_d = 1'b1;
      rd_d = rd_mux(i_araddr);
    end
    else if (rv_q && i_rready)
      rv_d = 1'b0;
    // Control write takes effect at once; data write waits for idle
    if (aw_q && w_q && !bv_q && awa_q != `NFH_REG_DATA)
    begin
      if (awa_q == `NFH_REG_CTRL && i_wstrb[1])
      begin
        kind_d  = nfh_kind_t'(wd_q[`NFH_F_KIND_HI:`NFH_F_KIND_LO]);
        guard_d = wd_q[`NFH_F_GUARD]; // R06 R13
        sel_d   = wd_q[`NFH_F_SELECT]; // R03
      end
      aw_d = 1'b0; w_d = 1'b0; bv_d = 1'b1;
    end
    if (done_q)
    begin
      aw_d = 1'b0; w_d = 1'b0; bv_d = 1'b1;
    end
    case (st_q)
      NFH_IDLE:
        if (go)
        begin
          byte_d = wd_q[7:0];
          // R12: strobe levels select command, address or data cycle
          cle_d = (kind_q == NFH_KIND_CMD); // R01
          ale_d = (kind_q == NFH_KIND_ADDR); // R02 R08
          oe_d  = (kind_q != NFH_KIND_DOUT);
          cnt_d = 8'(STROBE_CYC);
          st_d  = NFH_SETUP;
        end
      NFH_SETUP:
        if (cnt_q <= 8'h01)
        begin
          if (kind_q == NFH_KIND_DOUT)
          begin
            re_d = 1'b0; // R05 R21
            // Held low until the byte has crossed the synchroniser
            cnt_d = 8'(STROBE_CYC + `NFH_REA_CYC);
          end
          else
          begin
            we_d = 1'b0;
            cnt_d = 8'(STROBE_CYC);
          end
          st_d = NFH_LOW;
        end
        else
          cnt_d = cnt_q - 8'h01;
      NFH_LOW:
        if (cnt_q <= 8'h01)
        begin
          if (kind_q == NFH_KIND_DOUT)
          begin
            rbyte_d = port_in; // R05
            re_d = 1'b1;
          end
          else
            we_d = 1'b1; // R01 R02
          cnt_d = 8'(WHR_CYC);
          st_d = NFH_HIGH;
        end
        else
          cnt_d = cnt_q - 8'h01;
      NFH_HIGH:
        if (cnt_q <= 8'h01)
        begin
          cle_d = 1'b0; ale_d = 1'b0; oe_d = 1'b0;
          st_d = NFH_WAIT;
        end
        else
          cnt_d = cnt_q - 8'h01;
      NFH_WAIT:
      begin
        // Strobes stay high while idle; go ignores ready, so only software holding off writes keeps a busy device from seeing any
        done_d = 1'b1; // R14
        st_d = NFH_IDLE;
      end
      default: st_d = NFH_IDLE;
    endcase
    // Ready flops show a free holding slot in the same cycle it becomes free
    awr_d = !aw_d;
    wr_d  = !w_d;
    arr_d = !rv_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers; guard low and select high are the safe reset levels
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_q <= NFH_IDLE; kind_q <= NFH_KIND_CMD; cnt_q <= 8'h00;
      byte_q <= 8'h00; rbyte_q <= 8'h00; guard_q <= 1'b0; sel_q <= 1'b1;
      cle_q <= 1'b0; ale_q <= 1'b0; we_q <= 1'b1; re_q <= 1'b1;
      oe_q <= 1'b0; done_q <= 1'b0; aw_q <= 1'b0; w_q <= 1'b0;
      bv_q <= 1'b0; rv_q <= 1'b0; awa_q <= 4'h0; wd_q <= 32'h0;
      rd_q <= 32'h0; awr_q <= 1'b1; wr_q <= 1'b1; arr_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d; kind_q <= kind_d; cnt_q <= cnt_d; byte_q <= byte_d;
      rbyte_q <= rbyte_d; guard_q <= guard_d; sel_q <= sel_d;
      cle_q <= cle_d; ale_q <= ale_d; we_q <= we_d; re_q <= re_d;
      oe_q <= oe_d; done_q <= done_d; aw_q <= aw_d; w_q <= w_d;
      bv_q <= bv_d; rv_q <= rv_d; awa_q <= awa_d; wd_q <= wd_d;
      rd_q <= rd_d; awr_q <= awr_d; wr_q <= wr_d; arr_q <= arr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops; responses tied to 2'b00
  assign o_awready = awr_q;
  assign o_wready  = wr_q;
  assign o_bresp   = 2'b00;
  assign o_bvalid  = bv_q;
  assign o_arready = arr_q;
  assign o_rdata   = rd_q;
  assign o_rresp   = 2'b00;
  assign o_rvalid  = rv_q;
  assign o_cmd_latch      = cle_q;
  assign o_addr_latch     = ale_q;
  assign o_select_n       = sel_q;
  assign o_write_strobe_n = we_q;
  assign o_read_strobe_n  = re_q;
  assign o_guard_n        = guard_q;
  assign o_shared_byte_port    = byte_q;
  assign o_shared_byte_port_oe = oe_q;
endmodule

// *** verilog/nfh_cfg.svh ***
// Timing counts, codes and register offsets of the flash host controller
`ifndef NFH_CFG_SVH
`define NFH_CFG_SVH
`define NFH_CLK_NS        10
`define NFH_T_STROBE_NS   30
`define NFH_T_WHR_NS      60
`define NFH_STROBE_CYC    ((`NFH_T_STROBE_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_WHR_CYC       ((`NFH_T_WHR_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_T_REA_NS      20
`define NFH_SYNC_STAGES   2
// Extra read-low cycles: access time plus the pin synchroniser
`define NFH_REA_CYC \
  (((`NFH_T_REA_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS) + `NFH_SYNC_STAGES)
`define NFH_REG_CTRL      4'h0
`define NFH_REG_DATA      4'h4
`define NFH_REG_STAT      4'h8
`define NFH_REG_RDATA     4'hc
`define NFH_F_KIND_LO     8
`define NFH_F_KIND_HI     9
`define NFH_F_GUARD       10
`define NFH_F_SELECT      11
`define NFH_ST_BUSY       0
`define NFH_ST_READY      1
`define NFH_CMD_READ      8'h00
`define NFH_CMD_READ_GO   8'h30
`define NFH_CMD_COPY_RD   8'h35
`define NFH_CMD_COL_RD    8'h05
`define NFH_CMD_COL_RD_GO 8'he0
`define NFH_CMD_DIN       8'h80
`define NFH_CMD_PROG      8'h10
`define NFH_CMD_COL_DIN   8'h85
`define NFH_CMD_MP_FIRST  8'h11
`define NFH_CMD_MP_NEXT   8'h81
`define NFH_CMD_ERASE     8'h60
`define NFH_CMD_ERASE_GO  8'hd0
`define NFH_CMD_ID        8'h90
`define NFH_CMD_STATUS    8'h70
`define NFH_CMD_MSTATUS   8'h71
`define NFH_CMD_ECC       8'h7a
`define NFH_CMD_RESET     8'hff
`endif

// *** verilog/nfh_pkg.sv ***
// Types shared by the flash host controller
package nfh_pkg;
  typedef enum logic [1:0]
  {
    NFH_KIND_CMD,
    NFH_KIND_ADDR,
    NFH_KIND_DIN,
    NFH_KIND_DOUT
  } nfh_kind_t;
endpackage

// *** verilog/nfh_sync.sv ***
// Two-flop synchroniser for pins from the flash device
`timescale 1ns/1ps
module nfh_sync
#(
  parameter int W = 1
)
(
  input  wire logic         i_core_clk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // Stage one feeds only stage two
  always_comb
  begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule

// *** tb/nfh_monitor.sv ***
// Checker of host pin cycles and bus answers
`timescale 1ns/1ps
module nfh_monitor
(
  input wire logic       i_core_clk,
  input wire logic       i_arst_n,
  input wire logic       i_bready,
  input wire logic       i_rready,
  input wire logic       o_bvalid,
  input wire logic       o_rvalid,
  input wire logic       o_cmd_latch,
  input wire logic       o_addr_latch,
  input wire logic       o_write_strobe_n,
  input wire logic       o_read_strobe_n,
  input wire logic [7:0] o_shared_byte_port,
  input wire logic       o_shared_byte_port_oe
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////////////////
  chk_latch_excl: assert property (!(o_cmd_latch && o_addr_latch))
    else $error("latches both high");
  chk_strobe_len: assert property ($fell(o_write_strobe_n) |->
    !o_write_strobe_n [*3] ##1 o_write_strobe_n) else $error("strobe width");
  chk_byte_held: assert property (!o_write_strobe_n |->
    o_shared_byte_port_oe && $stable(o_shared_byte_port))
    else $error("byte moved");
  chk_latch_hold: assert property ($rose(o_write_strobe_n) |->
    $stable(o_cmd_latch) && $stable(o_addr_latch)) else $error("latch hold");
  chk_read_gap: assert property ($rose(o_write_strobe_n) |->
    o_read_strobe_n [*6]) else $error("read too soon");
  chk_read_only: assert property (!o_read_strobe_n |->
    !o_shared_byte_port_oe && !o_cmd_latch && !o_addr_latch
    && o_write_strobe_n) else $error("bad read cycle");
  chk_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("bvalid dropped");
  chk_r_hold: assert property (o_rvalid && !i_rready |=> o_rvalid)
    else $error("rvalid dropped");
endmodule
bind nfh_host nfh_monitor mon (.*);

// *** tb/nfh_flash_model.sv ***
// Behavioural flash device answering the host controller
`timescale 1ns/1ps
module nfh_flash_model
#(
  parameter logic [7:0] ID0 = 8'h11,
  parameter logic [7:0] ID1 = 8'h22
)
(
  input  wire logic        i_cle,
  input  wire logic        i_ale,
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_re_n,
  input  wire logic        i_wp_n,
  input  wire logic [7:0]  i_dq,
  input  wire logic [15:0] i_busy_ns,
  output logic      [7:0]  o_dq,
  output logic             o_busy
);
  logic [39:0] adr_q = 40'h0;
  logic [12:0] col_q = 13'h0;
  logic [7:0]  out_q = 8'h0;
  logic [2:0]  n_q = 3'h0;
  logic        id_q = 1'b0;
  logic        stby;
  event        go;
  // Standby only while ready; busy ignores select
  assign stby = i_ce_n && !o_busy;
  // Released port shows the inverse, never a stale byte
  assign o_dq = (!i_re_n && !i_ce_n && !i_cle && !i_ale)
    ? out_q : ~out_q;
  // Command and address cycles on the write strobe rise
  always @(posedge i_we_n)
    if (!i_ce_n && i_re_n && i_cle && !i_ale &&
        (!o_busy || i_dq inside {8'h70, 8'h71, 8'hff}))
    begin
      n_q = 3'h0;
      id_q = i_dq == 8'h90;
      if (id_q) col_q = 13'h0;
      if (i_dq inside {8'h30, 8'h35, 8'he0}) col_q = adr_q[12:0];
      if (i_dq inside {8'h30, 8'h35} ||
          i_wp_n && i_dq inside {8'h10, 8'h11, 8'hd0})
        ->go;
    end
    else if (!i_ce_n && i_re_n && i_ale && !i_cle && !o_busy)
    begin
      adr_q[n_q*8 +: 8] = i_dq;
      n_q = n_q + 3'h1;
    end
  // Each read strobe fall gives the next byte after a delay
  always @(negedge i_re_n)
    if (!i_ce_n)
    begin
      out_q <= #15 id_q ? (col_q[0] ? ID1 : ID0)
        : col_q[7:0] ^ adr_q[23:16];
      col_q = col_q + 13'h1;
    end
  // Busy pulls the open-drain line low for the bench's span
  initial o_busy = 1'b0;
  always @(go)
  begin
    o_busy = 1'b1;
    #(i_busy_ns) o_busy = 1'b0;
  end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench of the flash host controller
`timescale 1ns/1ps
`include "nfh_cfg.svh"
module tb_top;
  localparam logic [7:0] ID0 = 8'h5a; // Arbitrary maker code
  localparam logic [7:0] ID1 = 8'hc3; // Arbitrary part code
  logic        i_core_clk = 1'b0, i_arst_n = 1'b0, g = 1'b1, seen;
  logic [3:0]  i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hf;
  logic [31:0] i_wdata = 32'h0, o_rdata, v, seed = 32'hddf0;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic        i_arvalid = 1'b0, i_rready = 1'b0, busy, i_ready_busy_n;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp;
  logic        o_cmd_latch, o_addr_latch, o_select_n, o_write_strobe_n;
  logic        o_read_strobe_n, o_guard_n, o_shared_byte_port_oe;
  logic [7:0]  i_shared_byte_port, o_shared_byte_port, dev_q;
  logic [15:0] busy_ns = 16'd300;
  logic [12:0] col;
  logic [17:0] row;
  int          miscompares = 0, checks = 0;
  always #5 i_core_clk = ~i_core_clk;
  // Shared port and pulled-up ready line
  assign i_shared_byte_port = o_shared_byte_port_oe ? o_shared_byte_port : dev_q;
  assign i_ready_busy_n = !busy;
  nfh_host dut (.*);
  nfh_flash_model #(.ID0(ID0), .ID1(ID1)) dev (.i_cle(o_cmd_latch),
    .i_ale(o_addr_latch), .i_ce_n(o_select_n), .i_we_n(o_write_strobe_n),
    .i_re_n(o_read_strobe_n), .i_wp_n(o_guard_n), .i_dq(i_shared_byte_port),
    .i_busy_ns(busy_ns), .o_dq(dev_q), .o_busy(busy));
  //////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] pat(input logic [12:0] c);
    return {24'h0, c[7:0] ^ row[7:0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, s);
    checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  // Bus cycles hold each channel until its own ready
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do
    begin
      @(posedge i_core_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end
    while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do
    begin
      @(posedge i_core_clk);
      if (o_arready) i_arvalid <= 1'b0;
    end
    while (o_rvalid !== 1'b1);
    d = o_rdata;
    i_rready <= 1'b0;
  endtask
  task automatic pin(input logic [1:0] k, input logic [7:0] b);
    wr(`NFH_REG_CTRL, {20'h0, 1'b0, g, k, 8'h00});
    wr(`NFH_REG_DATA, {24'h0, b});
  endtask
  task automatic addr5(input logic [39:0] a);
    for (int i = 0; i < 5; i++) pin(2'd1, a[i*8 +: 8]);
  endtask
  // Polls only registers, so pins stay quiet while busy
  task automatic settle(output logic s);
    s = 1'b0;
    do
    begin
      rd(`NFH_REG_STAT, v);
      if (v[1] !== 1'b1) s = 1'b1;
    end
    while (v[1] !== 1'b1);
  endtask
  task automatic dout(input string n, input logic [31:0] e);
    pin(2'd3, 8'h00);
    rd(`NFH_REG_RDATA, v);
    chk(n, e, v);
  endtask
  task automatic conclude();
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge i_core_clk);
    v = 32'({o_select_n, o_guard_n, o_write_strobe_n, o_read_strobe_n,
      o_cmd_latch, o_addr_latch, o_shared_byte_port_oe});
    chk("reset pins", 32'h58, v);
    repeat (5) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    // Let the ready line cross the synchroniser before polling
    repeat (3) @(posedge i_core_clk);
    rd(`NFH_REG_STAT, v);
    chk("status", 32'h2, v & 32'h3);
    wr(4'h2, 32'h0);
    for (int n = 0; n < 3; n++)
    begin
      col = 13'(rnd() % 4100);
      row = 18'(rnd());
      busy_ns <= 16'(300 + rnd() % 700);
      if (n > 0) pin(2'd0, `NFH_CMD_READ);
      addr5({6'h0, row, 3'h0, col});
      pin(2'd0, `NFH_CMD_READ_GO);
      settle(seen);
      chk("read busy", 32'h1, 32'(seen));
      for (int i = 0; i < 3; i++) dout("byte", pat(col + 13'(i)));
      pin(2'd0, `NFH_CMD_COL_RD);
      pin(2'd1, 8'h7f);
      pin(2'd1, 8'h10);
      pin(2'd0, `NFH_CMD_COL_RD_GO);
      dout("last column", pat(13'd4223));
      g = n[0];
      pin(2'd0, `NFH_CMD_DIN);
      addr5({6'h0, row, 3'h0, col});
      pin(2'd2, 8'(rnd()));
      pin(2'd0, `NFH_CMD_PROG);
      settle(seen);
      chk("program busy", 32'(g), 32'(seen));
      g = 1'b1;
    end
    pin(2'd0, `NFH_CMD_ERASE);
    for (int i = 0; i < 3; i++) pin(2'd1, 8'(rnd()));
    pin(2'd0, `NFH_CMD_ERASE_GO);
    settle(seen);
    chk("erase busy", 32'h1, 32'(seen));
    // Two-page program: first page closed by 11, second confirmed by 10
    pin(2'd0, `NFH_CMD_DIN);
    addr5({6'h0, row, 16'h0});
    pin(2'd2, 8'(rnd()));
    pin(2'd0, `NFH_CMD_MP_FIRST);
    settle(seen);
    chk("first page busy", 32'h1, 32'(seen));
    pin(2'd0, `NFH_CMD_MP_NEXT);
    addr5({6'h0, row + 18'h40, 16'h0});
    pin(2'd2, 8'(rnd()));
    pin(2'd0, `NFH_CMD_PROG);
    settle(seen);
    chk("second page busy", 32'h1, 32'(seen));
    pin(2'd0, `NFH_CMD_ID);
    pin(2'd1, 8'h00);
    dout("id first", 32'(ID0));
    dout("id second", 32'(ID1));
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule
